// ===== common/oms_pkg.sv
// constants shared by the optical module control and status logic
package oms_pkg;
  // serial device addresses, write form with the direction bit clear
  localparam logic [7:0] DEV_ID_ADDR = 8'hA0;
  localparam logic [7:0] DEV_DIAG_ADDR = 8'hA2;
  // page select values carried between the bus engine and the memory
  localparam logic PAGE_ID = 1'b0;
  localparam logic PAGE_DIAG = 1'b1;
  // diagnostic page layout
  localparam logic [7:0] CTRL_STAT_OFF = 8'h6E;
  localparam logic [7:0] TX_POWER_OFF = 8'h66;
  localparam logic [7:0] RX_LEVEL_OFF = 8'h68;
  localparam int CS_PIN_BIT = 7;
  localparam int CS_SOFT_BIT = 6;
  localparam int CS_FAULT_BIT = 2;
  localparam int CS_LOS_BIT = 1;
  localparam logic CS_SOFT_RST = 1'b0;
  // identification page: byte 0 value is arbitrary, all other bytes read zero
  localparam logic [7:0] ID_TYPE_OFF = 8'h00;
  localparam logic [7:0] ID_TYPE_VAL = 8'h5A;
  localparam logic [7:0] MEM_RST = 8'h00;
  // factory thresholds for receive level and transmit power
  localparam logic [7:0] RX_LOST_THRESH = 8'h10;
  localparam logic [7:0] TX_POWER_LIMIT = 8'hF0;
  // serial engine states, gray coded along the write path
  typedef enum logic [3:0] {
    OMS_IDLE = 4'h0,
    OMS_DEV = 4'h1,
    OMS_ACK_DEV = 4'h3,
    OMS_WADDR = 4'h2,
    OMS_ACK_ADDR = 4'h6,
    OMS_WDATA = 4'h7,
    OMS_ACK_DATA = 4'h5,
    OMS_RD = 4'h4,
    OMS_RACK = 4'hC
  } oms_state_t;
endpackage

// ===== common/oms_mem_if.sv
// carrier between the serial engine and the two memory pages
`timescale 1ns/10ps
`default_nettype none
interface oms_mem_if;
  logic page;
  logic [7:0] addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic pin_dis;
  logic fault;
  logic los;
  logic [7:0] tx_power;
  logic [7:0] rx_level;
  logic soft_dis;
  modport ctl (
    output page, addr, wr_en, wr_data, pin_dis, fault, los, tx_power, rx_level,
    input rd_data, soft_dis
  );
  modport mem (
    input page, addr, wr_en, wr_data, pin_dis, fault, los, tx_power, rx_level,
    output rd_data, soft_dis
  );
endinterface
`default_nettype wire

// ===== src/oms_mem.sv
// identification and diagnostic memory pages with the control/status byte
`timescale 1ns/10ps
`default_nettype none
module oms_mem (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  oms_mem_if.mem mif
);
  logic [7:0] mem_q [0:255];
  logic [7:0] mem_d [0:255];
  logic soft_q;
  logic soft_d;

  // read-only identification contents
  function automatic logic [7:0] id_byte(input logic [7:0] a);
    id_byte = (a == oms_pkg::ID_TYPE_OFF) ? oms_pkg::ID_TYPE_VAL : oms_pkg::MEM_RST;
  endfunction

  function automatic logic is_cs(input logic pg, input logic [7:0] a);
    is_cs = (pg == oms_pkg::PAGE_DIAG) && (a == oms_pkg::CTRL_STAT_OFF);
  endfunction

  // ****************
  // write path
  // ****************
  always_comb begin
    mem_d = mem_q;
    soft_d = soft_q;
    if (mif.wr_en && mif.page == oms_pkg::PAGE_DIAG) begin
      if (is_cs(mif.page, mif.addr)) begin
        soft_d = mif.wr_data[oms_pkg::CS_SOFT_BIT];
      end else begin
        mem_d[mif.addr] = mif.wr_data;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      soft_q <= oms_pkg::CS_SOFT_RST;
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= oms_pkg::MEM_RST;
      end
    end else if (ce_in) begin
      soft_q <= soft_d;
      mem_q <= mem_d;
    end
  end

  // ****************
  // read path
  // ****************
  always_comb begin
    if (mif.page == oms_pkg::PAGE_ID) begin
      mif.rd_data = id_byte(mif.addr);
    end else if (is_cs(mif.page, mif.addr)) begin
      mif.rd_data = 8'h00;
      mif.rd_data[oms_pkg::CS_PIN_BIT] = mif.pin_dis;
      mif.rd_data[oms_pkg::CS_SOFT_BIT] = soft_q;
      mif.rd_data[oms_pkg::CS_FAULT_BIT] = mif.fault;
      mif.rd_data[oms_pkg::CS_LOS_BIT] = mif.los;
    end else if (mif.addr == oms_pkg::TX_POWER_OFF) begin
      mif.rd_data = mif.tx_power;
    end else if (mif.addr == oms_pkg::RX_LEVEL_OFF) begin
      mif.rd_data = mif.rx_level;
    end else begin
      mif.rd_data = mem_q[mif.addr];
    end
  end

  assign mif.soft_dis = soft_q;
endmodule
`default_nettype wire

// ===== src/oms_top.sv
// optical module control/status logic with its two-wire register access
`timescale 1ns/10ps
`default_nettype none
module oms_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic tx_disable_in,
  input wire logic tx_disable_driven_in,
  input wire logic laser_fault_in,
  input wire logic [7:0] tx_power_in,
  input wire logic [7:0] rx_level_in,
  output logic laser_en_out,
  output logic tx_fault_out,
  output logic tx_fault_oe_out,
  output logic receive_signal_lost_out
);
  oms_mem_if mif ();

  oms_mem u_mem (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .mif(mif)
  );

  // ****************
  // laser control and status
  // ****************
  logic pin_eff;
  logic unsafe;
  logic pin_q;
  logic pin_d;
  logic fault_q;
  logic fault_d;
  logic los_q;
  logic los_d;
  logic laser_en_q;
  logic laser_en_d;
  logic fault_oe_q;
  logic fault_oe_d;

  always_comb begin
    // a floating pin is pulled up, so the laser starts disabled
    pin_eff = tx_disable_driven_in ? tx_disable_in : 1'b1;
    unsafe = tx_power_in > oms_pkg::TX_POWER_LIMIT;
    pin_d = pin_eff;
    fault_d = fault_q;
    // asserting transmit-off clears the latch; release then restarts
    if (pin_eff) begin
      fault_d = 1'b0;
    end
    // a fault that is still present wins over the clear
    if (laser_fault_in || unsafe) begin
      fault_d = 1'b1;
    end
    laser_en_d = !(pin_eff || mif.soft_dis || fault_d);
    // open collector: pull low while healthy, release on fault
    fault_oe_d = !fault_d;
    los_d = rx_level_in < oms_pkg::RX_LOST_THRESH;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_q <= 1'b1;
      fault_q <= 1'b0;
      los_q <= 1'b1;
      laser_en_q <= 1'b0;
      fault_oe_q <= 1'b1;
    end else if (ce_in) begin
      pin_q <= pin_d;
      fault_q <= fault_d;
      los_q <= los_d;
      laser_en_q <= laser_en_d;
      fault_oe_q <= fault_oe_d;
    end
  end

  assign mif.pin_dis = pin_q;
  assign mif.fault = fault_q;
  assign mif.los = los_q;
  assign mif.tx_power = tx_power_in;
  assign mif.rx_level = rx_level_in;

  // ****************
  // two-wire serial engine
  // ****************
  oms_pkg::oms_state_t st_q;
  oms_pkg::oms_state_t st_d;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [2:0] bcnt_q;
  logic [2:0] bcnt_d;
  logic full_q;
  logic full_d;
  logic page_q;
  logic page_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic oe_q;
  logic oe_d;
  logic wr_en;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  function automatic logic dev_match(input logic [7:0] b);
    dev_match = (b[7:1] == oms_pkg::DEV_ID_ADDR[7:1]) ||
                (b[7:1] == oms_pkg::DEV_DIAG_ADDR[7:1]);
  endfunction

  always_comb begin
    scl_rise = scl_in && !scl_q;
    scl_fall = !scl_in && scl_q;
    start_c = scl_in && scl_q && sda_q && !sda_in;
    stop_c = scl_in && scl_q && !sda_q && sda_in;
    st_d = st_q;
    sh_d = sh_q;
    bcnt_d = bcnt_q;
    full_d = full_q;
    page_d = page_q;
    rw_d = rw_q;
    nack_d = nack_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    if (start_c) begin
      // a repeated start keeps the byte pointer for random reads
      st_d = oms_pkg::OMS_DEV;
      bcnt_d = 3'h0;
      full_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = oms_pkg::OMS_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      sh_d = {sh_q[6:0], sda_in};
      bcnt_d = bcnt_q + 3'h1;
      full_d = (bcnt_q == 3'h7);
      if (st_q == oms_pkg::OMS_RACK) begin
        nack_d = sda_in;
      end
    end else if (scl_fall) begin
      case (st_q)
        oms_pkg::OMS_DEV: begin
          if (full_q) begin
            if (dev_match(sh_q)) begin
              page_d = sh_q[1];
              rw_d = sh_q[0];
              oe_d = 1'b1;
              st_d = oms_pkg::OMS_ACK_DEV;
            end else begin
              st_d = oms_pkg::OMS_IDLE;
            end
          end
        end
        oms_pkg::OMS_ACK_DEV: begin
          bcnt_d = 3'h0;
          full_d = 1'b0;
          if (rw_q) begin
            sh_d = mif.rd_data;
            oe_d = !mif.rd_data[7];
            st_d = oms_pkg::OMS_RD;
          end else begin
            oe_d = 1'b0;
            st_d = oms_pkg::OMS_WADDR;
          end
        end
        oms_pkg::OMS_WADDR: begin
          if (full_q) begin
            ptr_d = sh_q;
            oe_d = 1'b1;
            st_d = oms_pkg::OMS_ACK_ADDR;
          end
        end
        oms_pkg::OMS_ACK_ADDR, oms_pkg::OMS_ACK_DATA: begin
          oe_d = 1'b0;
          bcnt_d = 3'h0;
          full_d = 1'b0;
          st_d = oms_pkg::OMS_WDATA;
        end
        oms_pkg::OMS_WDATA: begin
          if (full_q) begin
            // the memory decides which bits of a byte really store
            wr_en = 1'b1;
            ptr_d = ptr_q + 8'h01;
            oe_d = 1'b1;
            st_d = oms_pkg::OMS_ACK_DATA;
          end
        end
        oms_pkg::OMS_RD: begin
          if (full_q) begin
            oe_d = 1'b0;
            ptr_d = ptr_q + 8'h01;
            st_d = oms_pkg::OMS_RACK;
          end else begin
            oe_d = !sh_q[7];
          end
        end
        oms_pkg::OMS_RACK: begin
          bcnt_d = 3'h0;
          full_d = 1'b0;
          if (nack_q) begin
            oe_d = 1'b0;
            st_d = oms_pkg::OMS_IDLE;
          end else begin
            sh_d = mif.rd_data;
            oe_d = !mif.rd_data[7];
            st_d = oms_pkg::OMS_RD;
          end
        end
        default: begin
          oe_d = 1'b0;
          st_d = oms_pkg::OMS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= oms_pkg::OMS_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h00;
      bcnt_q <= 3'h0;
      full_q <= 1'b0;
      page_q <= oms_pkg::PAGE_ID;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
      oe_q <= 1'b0;
    end else if (ce_in) begin
      st_q <= st_d;
      scl_q <= scl_in;
      sda_q <= sda_in;
      sh_q <= sh_d;
      bcnt_q <= bcnt_d;
      full_q <= full_d;
      page_q <= page_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
    end
  end

  // write strobe only counts while the clock enable lets state move
  assign mif.page = page_q;
  assign mif.addr = ptr_q;
  assign mif.wr_en = wr_en && ce_in;
  assign mif.wr_data = sh_q;

  // ****************
  // pin outputs
  // ****************
  logic low_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      low_q <= 1'b0;
    end else if (ce_in) begin
      low_q <= 1'b0;
    end
  end

  assign sda_out = low_q;
  assign sda_oe_out = oe_q;
  assign laser_en_out = laser_en_q;
  assign tx_fault_out = low_q;
  assign tx_fault_oe_out = fault_oe_q;
  assign receive_signal_lost_out = los_q;
endmodule
`default_nettype wire

// ===== verif/oms_chk.sv
// pin-level assertions for the optical module control block
`timescale 1ns/10ps
`default_nettype none
module oms_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic tx_disable_in,
  input wire logic tx_disable_driven_in,
  input wire logic laser_fault_in,
  input wire logic [7:0] tx_power_in,
  input wire logic [7:0] rx_level_in,
  input wire logic laser_en_out,
  input wire logic tx_fault_out,
  input wire logic tx_fault_oe_out,
  input wire logic receive_signal_lost_out
);
  // a floating pin counts as asserted through the pull-up
  logic pin_off;
  assign pin_off = tx_disable_in | ~tx_disable_driven_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  fault_set_a:
    assert property (ce_in && laser_fault_in |=> !tx_fault_oe_out && !laser_en_out)
    else $error("fault not flagged");
  fault_hold_a:
    assert property (ce_in && !tx_fault_oe_out && !pin_off |=> !tx_fault_oe_out)
    else $error("fault cleared early");
  pin_off_a:
    assert property (ce_in && pin_off |=> !laser_en_out)
    else $error("laser on with pin high");
  power_off_a:
    assert property (ce_in && tx_power_in > oms_pkg::TX_POWER_LIMIT |=> !laser_en_out)
    else $error("laser on at unsafe power");
  los_follow_a:
    assert property (ce_in |=>
      receive_signal_lost_out == ($past(rx_level_in) < oms_pkg::RX_LOST_THRESH))
    else $error("signal lost wrong");
  open_drain_a:
    assert property (!tx_fault_out && !sda_out)
    else $error("open drain drives high");
  laser_ok_a:
    assert property (laser_en_out |-> tx_fault_oe_out)
    else $error("laser on during fault");
  sda_stable_a:
    assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data moved with clock high");
endmodule
`default_nettype wire

// ===== verif/oms_host.sv
// host board model: two-wire bus master and data-line pull-up
`timescale 1ns/10ps
`default_nettype none
module oms_host (
  input wire logic clk_in,
  input wire logic dev_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic pull_q;
  // pull-up: the wire is high unless a party pulls it low
  assign sda_out = ~(pull_q | dev_oe_in);
  initial begin
    pull_q = 1'b0;
    scl_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // phases of 4 clocks or more, since the block samples the bus synchronously
  task automatic bit_io(input logic b, output logic s);
    pull_q = ~b;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    s = sda_out;
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic start_c();
    pull_q = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    pull_q = 1'b1;
    tick(4);
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic stop_c();
    pull_q = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    pull_q = 1'b0;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] w, input logic nine, output logic [7:0] r,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], s);
      r[i] = s;
    end
    bit_io(nine, s);
    ack = ~s;
  endtask
  task automatic write_reg(input logic [7:0] dev, input logic [7:0] off,
                           input logic [7:0] data, output logic [2:0] acks);
    logic [7:0] r;
    start_c();
    xfer(dev, 1'b1, r, acks[2]);
    xfer(off, 1'b1, r, acks[1]);
    xfer(data, 1'b1, r, acks[0]);
    stop_c();
  endtask
  task automatic read_reg(input logic [7:0] dev, input logic [7:0] off,
                          output logic [7:0] data, output logic ack);
    logic [7:0] r;
    logic a;
    start_c();
    xfer(dev, 1'b1, r, ack);
    xfer(off, 1'b1, r, a);
    start_c();
    xfer(dev | 8'h01, 1'b1, r, a);
    xfer(8'hFF, 1'b1, data, a);
    stop_c();
  endtask
endmodule
`default_nettype wire

// ===== verif/optical_module_control_status_bench.sv
// self-checking bench for the optical module control block
`timescale 1ns/10ps
`default_nettype none
module optical_module_control_status_bench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic scl, sda, sda_out, sda_oe_out, tx_fault_out, tx_fault_oe_out, laser_en, los;
  logic tx_dis = 1'b0;
  logic tx_drv = 1'b0;
  logic ce = 1'b1;
  logic lfault = 1'b0;
  logic [7:0] tx_pwr = 8'hF0;
  logic [7:0] rx_lvl = 8'h00;
  logic [7:0] d;
  logic a;
  logic [2:0] k;
  int failures = 0;
  int num_checks = 0;
  localparam logic [7:0] DIAG = oms_pkg::DEV_DIAG_ADDR;
  localparam logic [7:0] CS = oms_pkg::CTRL_STAT_OFF;
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  oms_host host_u (.clk_in(clk_in), .dev_oe_in(sda_oe_out), .scl_out(scl), .sda_out(sda));
  oms_top dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .tx_disable_in(tx_dis),
    .tx_disable_driven_in(tx_drv), .laser_fault_in(lfault), .tx_power_in(tx_pwr),
    .rx_level_in(rx_lvl), .laser_en_out(laser_en), .tx_fault_out(tx_fault_out),
    .tx_fault_oe_out(tx_fault_oe_out), .receive_signal_lost_out(los)
  );
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_pages();
    host_u.read_reg(oms_pkg::DEV_ID_ADDR, 8'h00, d, a);
    check({7'h00, a}, 8'h01, "id ack");
    check(d, oms_pkg::ID_TYPE_VAL, "id byte 0");
    host_u.read_reg(oms_pkg::DEV_ID_ADDR, 8'hFF, d, a);
    check(d, 8'h00, "id byte 255");
    host_u.read_reg(8'hB0, 8'h00, d, a);
    check({7'h00, a}, 8'h00, "foreign ack");
    host_u.read_reg(DIAG, CS, d, a);
    check({7'h00, a}, 8'h01, "diag ack");
    check(d, 8'h82, "status floating");
    check({7'h00, laser_en}, 8'h00, "laser floating");
    check({6'h00, sda_out, tx_fault_out}, 8'h00, "low drivers");
    $display("test pages done");
  endtask
  task automatic test_pin();
    tx_drv = 1'b1;
    rx_lvl = 8'h10;
    host_u.tick(1);
    check({7'h00, laser_en}, 8'h01, "laser pin low");
    check({7'h00, los}, 8'h00, "lost at limit");
    rx_lvl = 8'h0F;
    tx_dis = 1'b1;
    host_u.tick(1);
    check({7'h00, laser_en}, 8'h00, "laser pin high");
    check({7'h00, los}, 8'h01, "lost below");
    host_u.read_reg(DIAG, CS, d, a);
    check(d, 8'h82, "status pin high");
    tx_dis = 1'b0;
    host_u.read_reg(DIAG, CS, d, a);
    check(d, 8'h02, "status pin low");
    $display("test pin done");
  endtask
  task automatic test_soft();
    rx_lvl = 8'h80;
    host_u.write_reg(DIAG, CS, 8'hFF, k);
    check({5'h00, k}, 8'h07, "write acks");
    host_u.read_reg(DIAG, CS, d, a);
    check(d, 8'h40, "soft bit only");
    check({7'h00, laser_en}, 8'h00, "soft off");
    host_u.read_reg(DIAG, oms_pkg::TX_POWER_OFF, d, a);
    check(d, 8'hF0, "power monitor");
    host_u.write_reg(DIAG, CS, 8'h00, k);
    host_u.tick(1);
    check({7'h00, laser_en}, 8'h01, "soft on");
    $display("test soft done");
  endtask
  // cause 0 is a laser fault, cause 1 unsafe output power
  task automatic test_fault();
    for (int c = 0; c < 2; c++) begin
      lfault = (c == 0);
      tx_pwr = (c == 0) ? 8'hF0 : 8'hF1;
      host_u.tick(1);
      check({6'h00, laser_en, tx_fault_oe_out}, 8'h00, "fault set");
      lfault = 1'b0;
      tx_pwr = 8'hF0;
      host_u.tick(3);
      check({7'h00, tx_fault_oe_out}, 8'h00, "fault latch");
      host_u.read_reg(DIAG, CS, d, a);
      check(d, 8'h04, "status fault");
      tx_dis = 1'b1;
      host_u.tick(1);
      check({7'h00, tx_fault_oe_out}, 8'h01, "fault clear");
      tx_dis = 1'b0;
      host_u.tick(1);
      check({7'h00, laser_en}, 8'h01, "restart");
    end
    $display("test fault done");
  endtask
  // clock enable low freezes state; a mid-run reset must clear the soft bit
  task automatic test_hold();
    ce = 1'b0;
    tx_dis = 1'b1;
    rx_lvl = 8'h00;
    host_u.tick(2);
    check({6'h00, laser_en, los}, 8'h02, "frozen");
    ce = 1'b1;
    host_u.tick(1);
    check({6'h00, laser_en, los}, 8'h01, "thawed");
    host_u.write_reg(DIAG, CS, 8'h40, k);
    sys_rst_in = 1'b1;
    host_u.tick(2);
    check({5'h00, laser_en, tx_fault_oe_out, los}, 8'h03, "in reset");
    sys_rst_in = 1'b0;
    tx_dis = 1'b0;
    host_u.tick(1);
    check({7'h00, laser_en}, 8'h01, "soft cleared");
    host_u.read_reg(DIAG, CS, d, a);
    check(d, 8'h02, "status after reset");
    $display("test hold done");
  endtask
  initial begin
    repeat (40000) @(posedge clk_in);
    failures++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    print_verdict();
  end
  // spacing of transmit-off assertions is shortened to keep the run brief
  initial begin
    host_u.tick(6);
    sys_rst_in = 1'b0;
    test_pages();
    test_pin();
    test_soft();
    test_fault();
    test_hold();
    print_verdict();
  end
endmodule
bind oms_top oms_chk chk_u (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .tx_disable_in(tx_disable_in),
  .tx_disable_driven_in(tx_disable_driven_in), .laser_fault_in(laser_fault_in),
  .tx_power_in(tx_power_in), .rx_level_in(rx_level_in), .laser_en_out(laser_en_out),
  .tx_fault_out(tx_fault_out), .tx_fault_oe_out(tx_fault_oe_out),
  .receive_signal_lost_out(receive_signal_lost_out)
);
`default_nettype wire
